// ==== logic/iahc_isa_adapter_host_control.sv ====
`timescale 1ns/1ps
`include "iahc_defines.svh"
module iahc_isa_adapter_host_control (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [9:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic [19:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [6:0] base_address_switches,
    input wire logic [3:0] line_mode_switches,
    input wire logic controller_irq,
    input wire logic [17:0] ctrl_dma_addr,
    output logic [7:0] io_rdata_ff,
    output logic io_sel_ff,
    output logic mem_sel_ff,
    output logic io_chrdy_ff,
    output logic sram_sel_ff,
    output logic ctrl_reg_sel_ff,
    output logic [17:0] sram_addr_ff,
    output logic [17:0] ctrl_sram_addr_ff,
    output logic irq_out_ff,
    output logic irq_share_en_ff,
    output logic [2:0] irq_code_ff,
    output logic board_reset_ff,
    output logic local_loop_ff,
    output logic remote_loop_ff,
    output iahc_pkg::iahc_line_mode_t line_mode_ff,
    output logic line_mode_ok_ff
);
    import iahc_pkg::*;
    logic host_window_enable_ff;
    logic window_target_select_ff;
    logic [3:0] window_page_select_ff;
    logic [4:0] window_base_select_ff;
    logic zero_wait_select_ff;
    logic line_mode_source_select_ff;
    logic [3:0] line_mode_code_ff;
    logic [2:0] wait_cnt_ff;
    logic [15:0] customer_security_word;
    wire logic [9:0] io_base;
    wire logic base_ok;
    wire logic io_hit;
    wire logic [2:0] reg_ofs;
    wire logic wr_any;
    wire logic irq_enabled_status;
    wire logic controller_irq_pending_n;
    wire logic board_reset_status;
    wire logic [3:0] eff_line_code;
    wire logic [19:0] win_start;
    wire logic win_hit;
    wire logic low_256;
    wire logic mem_cycle;
    wire logic rst_trigger;
    wire logic [7:0] rd_mux;
    wire logic [7:0] rd_winctl;
    wire logic [7:0] rd_winbase;
    wire logic [7:0] rd_wait;
    wire logic [7:0] rd_reset;
    wire logic [7:0] rd_share;
    wire logic [7:0] rd_line;
    wire logic board_reset;

    function automatic logic is_wr(input logic [2:0] ofs, input logic [2:0] tgt,
                                   input logic hit, input logic wr);
        is_wr = hit && wr && (ofs == tgt);
    endfunction

    // Switches give A8..A3; A9 forced high keeps base within 200H..3FFH
    assign io_base = {1'b1, base_address_switches[5:0], 3'h0};
    assign base_ok = (io_base >= `IAHC_IO_MIN) && (io_base <= `IAHC_IO_MAX); // see RL2
    assign io_hit = base_ok && (io_addr[9:3] == io_base[9:3]) && (io_rd || io_wr); // see RL1
    assign reg_ofs = io_addr[2:0]; // see RL1
    assign wr_any = io_hit && io_wr;

    assign irq_enabled_status = (irq_code_ff != 3'h0); // see RL9
    assign controller_irq_pending_n = ~controller_irq; // see RL12
    assign board_reset_status = ~board_reset; // see RL13
    assign eff_line_code = line_mode_source_select_ff ? line_mode_code_ff
                                                      : line_mode_switches; // see RL16
    assign customer_security_word = `IAHC_SEC_WORD; // see RL18

    // Window sits at 80000 + base*16K, so 32 slots cover 80000..FFFFF
    assign win_start = `IAHC_WIN_SEG_BASE + {1'b0, window_base_select_ff, 14'h0}; // see RL4
    assign win_hit = (mem_addr[19:14] == win_start[19:14]); // see RL3
    assign low_256 = (mem_addr[13:0] < `IAHC_CTRL_REG_BYTES); // see RL8
    assign mem_cycle = (mem_rd || mem_wr) && win_hit && host_window_enable_ff; // see RL7
    assign rst_trigger = is_wr(reg_ofs, `IAHC_OFS_RESET, io_hit, io_wr) && io_wdata[7]; // see RL14

    assign rd_winctl = {host_window_enable_ff, window_target_select_ff, 2'b00,
                        window_page_select_ff};
    assign rd_winbase = {3'b000, window_base_select_ff};
    assign rd_wait = {1'b0, zero_wait_select_ff, 1'b1, 5'h00}; // see RL22
    assign rd_reset = {2'b00, controller_irq_pending_n, board_reset_status,
                       4'h8}; // see RL12
    assign rd_share = {irq_share_en_ff, irq_enabled_status, 6'h00}; // see RL10
    assign rd_line = {local_loop_ff, remote_loop_ff, 1'b0, line_mode_source_select_ff,
                      eff_line_code}; // see RL17
    assign rd_mux = (reg_ofs == `IAHC_OFS_WINCTL) ? rd_winctl :
                    (reg_ofs == `IAHC_OFS_WINBASE) ? rd_winbase :
                    (reg_ofs == `IAHC_OFS_WAIT) ? rd_wait :
                    (reg_ofs == `IAHC_OFS_RESET) ? rd_reset :
                    (reg_ofs == `IAHC_OFS_SHARE) ? rd_share :
                    (reg_ofs == `IAHC_OFS_LINE) ? rd_line :
                    (reg_ofs == `IAHC_OFS_SECLO) ? customer_security_word[7:0] :
                    customer_security_word[15:8]; // see RL18

    iahc_board_reset u_reset (
        .mclk(mclk),
        .rst(rst),
        .trigger(rst_trigger),
        .board_reset_ff(board_reset)
    );

    iahc_line_decode u_line (
        .mclk(mclk),
        .rst(rst),
        .code(eff_line_code),
        .mode_ff(line_mode_ff),
        .supported_ff(line_mode_ok_ff)
    );

    always_ff @(posedge mclk) begin
        if (rst) begin
            host_window_enable_ff <= 1'b0;
            window_target_select_ff <= 1'b0;
            window_page_select_ff <= 4'h0;
        end else if (is_wr(reg_ofs, `IAHC_OFS_WINCTL, io_hit, io_wr)) begin
            host_window_enable_ff <= io_wdata[7]; // see RL7
            window_target_select_ff <= io_wdata[6]; // see RL8
            window_page_select_ff <= io_wdata[3:0]; // see RL5
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_code_ff <= 3'h0;
            window_base_select_ff <= 5'h00;
        end else if (is_wr(reg_ofs, `IAHC_OFS_WINBASE, io_hit, io_wr)) begin
            irq_code_ff <= io_wdata[7:5]; // see RL9
            window_base_select_ff <= io_wdata[4:0]; // see RL4
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            zero_wait_select_ff <= 1'b0; // see RL15
        end else if (is_wr(reg_ofs, `IAHC_OFS_WAIT, io_hit, io_wr)) begin
            zero_wait_select_ff <= io_wdata[6];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_share_en_ff <= 1'b0; // see RL11
        end else if (is_wr(reg_ofs, `IAHC_OFS_SHARE, io_hit, io_wr)) begin
            irq_share_en_ff <= io_wdata[7]; // see RL11
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            local_loop_ff <= 1'b0;
            remote_loop_ff <= 1'b0;
            line_mode_source_select_ff <= 1'b0; // see RL16
            line_mode_code_ff <= 4'h0;
        end else if (is_wr(reg_ofs, `IAHC_OFS_LINE, io_hit, io_wr)) begin
            local_loop_ff <= io_wdata[7];
            remote_loop_ff <= io_wdata[6];
            line_mode_source_select_ff <= io_wdata[`IAHC_BIT_LINE_SRC]; // see RL21
            line_mode_code_ff <= io_wdata[3:0]; // see RL17
        end
    end

    // Waits: chrdy drops for a fixed count after a fresh access unless zero-wait
    always_ff @(posedge mclk) begin
        if (rst) begin
            wait_cnt_ff <= 3'h0;
            io_chrdy_ff <= 1'b1;
        end else begin
            if ((io_hit || mem_cycle) && !zero_wait_select_ff && wait_cnt_ff == 3'h0 &&
                io_chrdy_ff) begin
                wait_cnt_ff <= `IAHC_WAIT_CYC; // see RL15
                io_chrdy_ff <= 1'b0;
            end else if (wait_cnt_ff != 3'h0) begin
                wait_cnt_ff <= wait_cnt_ff - 3'h1;
                io_chrdy_ff <= (wait_cnt_ff == 3'h1);
            end else begin
                io_chrdy_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            io_rdata_ff <= 8'h00;
            io_sel_ff <= 1'b0;
            mem_sel_ff <= 1'b0;
            sram_sel_ff <= 1'b0;
            ctrl_reg_sel_ff <= 1'b0;
            sram_addr_ff <= 18'h00000;
            ctrl_sram_addr_ff <= 18'h00000;
            irq_out_ff <= 1'b0;
            board_reset_ff <= 1'b1;
        end else begin
            io_rdata_ff <= (io_hit && io_rd) ? rd_mux : 8'h00;
            io_sel_ff <= io_hit;
            mem_sel_ff <= mem_cycle; // see RL7
            sram_sel_ff <= mem_cycle && (window_target_select_ff || !low_256); // see RL8
            ctrl_reg_sel_ff <= mem_cycle && !window_target_select_ff && low_256; // see RL8
            sram_addr_ff <= {window_page_select_ff, mem_addr[13:0]}; // see RL5
            // Controller has its own oscillator; its address must reach us retimed (see RL19)
            ctrl_sram_addr_ff <= ctrl_dma_addr; // see RL6
            irq_out_ff <= irq_enabled_status && controller_irq; // see RL9
            board_reset_ff <= board_reset;
        end
    end
endmodule

// ==== logic/iahc_defines.svh ====
// Notes on behaviour
// RL1: Decode exactly eight consecutive I/O byte addresses from the switch-selected base.
// RL2: Base address is accepted only within 200H to 3FFH.
// RL3: On-board memory appears as one bank-switched 16K window below one megabyte.
// RL4: Five window-base bits place the window in segments 80000 through F0000.
// RL5: Four page bits choose one of sixteen 16K SRAM pages.
// RL6: Serial controller sees the whole 256K SRAM linearly, regardless of page.
// RL7: Window enable set answers host memory cycles; clear ignores them.
// RL8: Target bit set maps first 256 window bytes to SRAM, clear to controller.
// RL9: Interrupt code 000 disables interrupts; 001 to 111 enable them.
// RL10: Interrupt-enabled state reads back as status bit at base+4.
// RL11: Sharing bit enables shared interrupt requests; clears at power-up.
// RL12: Controller interrupt pending reads at base+3, active low.
// RL13: Board reset status reads 0 while reset active, 1 when inactive.
// RL14: Top data bit written to base+3 triggers board reset; others ignored.
// RL15: Wait-select 1 gives zero wait states, 0 inserts waits; 0 at power-up.
// RL16: Mode-source 0 takes line mode from switches, 1 from register; 0 at power-up.
// RL17: Line-mode bits read back switches or last written value per mode-source.
// RL18: Security word reads at base+6 low, base+7 high; default FFFF.
// RL19: Serial controller clocked by independent 16MHz oscillator, not host clock.
// RL20: Line-mode code decodes to listed interfaces; other codes unsupported.
// RL21: Mode-source select sits at bit 4 of base+5.
// RL22: Unused bits ignore writes and read back fixed constants.
`ifndef IAHC_DEFINES_SVH
`define IAHC_DEFINES_SVH
`define IAHC_OFS_WINCTL 3'h0
`define IAHC_OFS_WINBASE 3'h1
`define IAHC_OFS_WAIT 3'h2
`define IAHC_OFS_RESET 3'h3
`define IAHC_OFS_SHARE 3'h4
`define IAHC_OFS_LINE 3'h5
`define IAHC_OFS_SECLO 3'h6
`define IAHC_OFS_SECHI 3'h7
`define IAHC_IO_MIN 10'h200
`define IAHC_IO_MAX 10'h3FF
`define IAHC_SEC_WORD 16'hFFFF
`define IAHC_BIT_LINE_SRC 4
`define IAHC_WIN_SEG_BASE 20'h80000
`define IAHC_CTRL_REG_BYTES 14'h0100
`define IAHC_RST_PULSE_CYC 4'h8
`define IAHC_WAIT_CYC 3'h3
`endif

// ==== logic/iahc_pkg.sv ====
package iahc_pkg;
    typedef enum logic [3:0] {
        IAHC_LM_HIZ = 4'h0,
        IAHC_LM_RS232 = 4'h2,
        IAHC_LM_RS485T = 4'h4,
        IAHC_LM_RS485 = 4'h5,
        IAHC_LM_LOOP_SE = 4'hA,
        IAHC_LM_LOOP_DIFF = 4'hB,
        IAHC_LM_RS530 = 4'hD,
        IAHC_LM_V35 = 4'hE,
        IAHC_LM_RS530A = 4'hF
    } iahc_line_mode_t;
    typedef enum logic [2:0] {
        IAHC_RS_IDLE = 3'b001,
        IAHC_RS_PULSE = 3'b010,
        IAHC_RS_DONE = 3'b100
    } iahc_rst_state_t;
endpackage

// ==== logic/iahc_line_decode.sv ====
`timescale 1ns/1ps
`include "iahc_defines.svh"
module iahc_line_decode (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] code,
    output iahc_pkg::iahc_line_mode_t mode_ff,
    output logic supported_ff
);
    import iahc_pkg::*;
    wire logic known;
    assign known = (code == 4'h0) || (code == 4'h2) || (code == 4'h4) || (code == 4'h5) ||
                   (code == 4'hA) || (code == 4'hB) || (code >= 4'hD); // see RL20
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_ff <= IAHC_LM_HIZ;
            supported_ff <= 1'b1;
        end else begin
            // Unsupported codes fall back to all-lines-off to protect receivers
            mode_ff <= known ? iahc_line_mode_t'(code) : IAHC_LM_HIZ; // see RL20
            supported_ff <= known;
        end
    end
endmodule

// ==== logic/iahc_board_reset.sv ====
`timescale 1ns/1ps
`include "iahc_defines.svh"
module iahc_board_reset (
    input wire logic mclk,
    input wire logic rst,
    input wire logic trigger,
    output logic board_reset_ff
);
    import iahc_pkg::*;
    iahc_rst_state_t state_ff;
    iahc_rst_state_t nxt_state;
    logic [3:0] cnt_ff;
    wire logic cnt_done;
    assign cnt_done = (cnt_ff == `IAHC_RST_PULSE_CYC - 4'h1);
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            IAHC_RS_IDLE: begin
                if (trigger) begin
                    nxt_state = IAHC_RS_PULSE; // see RL14
                end
            end
            IAHC_RS_PULSE: begin
                if (cnt_done) begin
                    nxt_state = IAHC_RS_DONE;
                end
            end
            IAHC_RS_DONE: nxt_state = IAHC_RS_IDLE;
            default: nxt_state = IAHC_RS_IDLE;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= IAHC_RS_PULSE;
            cnt_ff <= 4'h0;
            board_reset_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= (state_ff == IAHC_RS_PULSE) ? cnt_ff + 4'h1 : 4'h0;
            board_reset_ff <= (nxt_state == IAHC_RS_PULSE);
        end
    end
endmodule

// ==== tb/iahc_host_control_properties.sv ====
`timescale 1ns/1ps
module iahc_host_control_properties (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [9:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic [19:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [6:0] base_address_switches,
    input wire logic controller_irq,
    input wire logic [17:0] ctrl_dma_addr,
    input wire logic [7:0] io_rdata_ff,
    input wire logic io_sel_ff,
    input wire logic mem_sel_ff,
    input wire logic sram_sel_ff,
    input wire logic ctrl_reg_sel_ff,
    input wire logic [17:0] sram_addr_ff,
    input wire logic [17:0] ctrl_sram_addr_ff,
    input wire logic irq_out_ff,
    input wire logic irq_share_en_ff,
    input wire logic [2:0] irq_code_ff,
    input wire logic board_reset_ff,
    input wire iahc_pkg::iahc_line_mode_t line_mode_ff,
    input wire logic line_mode_ok_ff
);
    import iahc_pkg::*;
    // A9 is wired high, so no switch setting can place the block below 200H
    wire logic hit = (io_rd || io_wr) && io_addr[9:3] == {1'b1, base_address_switches[5:0]};
    wire logic [2:0] ofs = io_addr[2:0];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    io_decode_a: assert property (io_sel_ff == $past(hit))
        else $error("io select does not follow the decode");
    io_range_a: assert property ((io_rd || io_wr) && !io_addr[9] |=> !io_sel_ff)
        else $error("io select below the allowed range");
    status_read_a: assert property (hit && io_rd && ofs == 3'h4 |=>
        io_rdata_ff == {$past(irq_share_en_ff), $past(irq_code_ff) != 3'h0, 6'h00})
        else $error("interrupt status read is wrong");
    pending_read_a: assert property (hit && io_rd && ofs == 3'h3 |=>
        io_rdata_ff[5] == !$past(controller_irq) && io_rdata_ff[3:0] == 4'h8)
        else $error("pending status read is wrong");
    irq_gate_a: assert property (irq_code_ff == 3'h0 |=> !irq_out_ff)
        else $error("interrupt passed while disabled");
    irq_pass_a: assert property (controller_irq && irq_code_ff != 3'h0 |=> irq_out_ff)
        else $error("interrupt blocked while enabled");
    sw_reset_a: assert property (hit && io_wr && ofs == 3'h3 && io_wdata[7] &&
        !board_reset_ff |-> ##[1:2] board_reset_ff [*8])
        else $error("software board reset pulse too short");
    window_range_a: assert property ((mem_rd || mem_wr) && !mem_addr[19] |=> !mem_sel_ff)
        else $error("window answered below segment 80000");
    page_addr_a: assert property (mem_sel_ff |-> sram_addr_ff[13:0] == $past(mem_addr[13:0]))
        else $error("window offset not carried to sram");
    target_split_a: assert property (mem_sel_ff && $past(mem_addr[13:8]) != 6'h00 |->
        sram_sel_ff && !ctrl_reg_sel_ff)
        else $error("window above 256 bytes not routed to sram");
    linear_dma_a: assert property (!$past(rst) |-> ctrl_sram_addr_ff == $past(ctrl_dma_addr))
        else $error("controller sram address not linear");
    mode_fallback_a: assert property (!line_mode_ok_ff |-> line_mode_ff == IAHC_LM_HIZ)
        else $error("unsupported line mode not forced off");
    cover property (hit && io_wr && ofs == 3'h3 && io_wdata[7]);
    cover property (mem_sel_ff && ctrl_reg_sel_ff);
    cover property (irq_out_ff);
endmodule
bind iahc_isa_adapter_host_control iahc_host_control_properties u_props (
    .mclk(mclk), .rst(rst), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .base_address_switches(base_address_switches), .controller_irq(controller_irq),
    .ctrl_dma_addr(ctrl_dma_addr), .io_rdata_ff(io_rdata_ff), .io_sel_ff(io_sel_ff),
    .mem_sel_ff(mem_sel_ff), .sram_sel_ff(sram_sel_ff), .ctrl_reg_sel_ff(ctrl_reg_sel_ff),
    .sram_addr_ff(sram_addr_ff), .ctrl_sram_addr_ff(ctrl_sram_addr_ff),
    .irq_out_ff(irq_out_ff), .irq_share_en_ff(irq_share_en_ff), .irq_code_ff(irq_code_ff),
    .board_reset_ff(board_reset_ff), .line_mode_ff(line_mode_ff),
    .line_mode_ok_ff(line_mode_ok_ff));

// ==== tb/iahc_isa_host_model.sv ====
`timescale 1ns/1ps
module iahc_isa_host_model (
    input wire logic mclk,
    input wire logic io_chrdy_ff,
    input wire logic [7:0] io_rdata_ff,
    output logic [9:0] io_addr,
    output logic io_rd,
    output logic io_wr,
    output logic [7:0] io_wdata,
    output logic [19:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr
);
    initial begin
        {io_rd, io_wr, mem_rd, mem_wr} = 4'h0;
        io_addr = 10'h000;
        io_wdata = 8'h00;
        mem_addr = 20'h00000;
    end
    // Strobe held until ready or for at most 8 cycles; released lines show the inverse, never a stale value
    task automatic io_cycle(input logic wr, input logic [9:0] a, input logic [7:0] d,
                            output logic [7:0] q, output int n);
        @(negedge mclk);
        io_addr = a;
        io_wdata = d;
        io_wr = wr;
        io_rd = !wr;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (io_chrdy_ff !== 1'b1 && n < 8);
        q = io_rdata_ff;
        {io_rd, io_wr} = 2'b00;
        io_addr = ~a;
        io_wdata = ~d;
    endtask
    task automatic mem_cycle(input logic wr, input logic [19:0] a);
        int k;
        @(negedge mclk);
        mem_addr = a;
        mem_wr = wr;
        mem_rd = !wr;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (io_chrdy_ff !== 1'b1 && k < 8);
        {mem_rd, mem_wr} = 2'b00;
        mem_addr = ~a;
    endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import iahc_pkg::*;
    typedef struct packed {logic wr; logic [2:0] ofs; logic [7:0] d; logic [7:0] e;} iahc_row_t;
    localparam logic [15:0] SUP = 16'hEC35;
    logic mclk = 1'b0, rst = 1'b1, controller_irq = 1'b0;
    logic [6:0] base_address_switches = 7'h20;
    logic [3:0] line_mode_switches = 4'hD;
    logic [17:0] ctrl_dma_addr = 18'h00000, sram_addr_ff, ctrl_sram_addr_ff;
    logic [9:0] io_addr;
    logic [7:0] io_wdata, io_rdata_ff, q;
    logic [19:0] mem_addr;
    logic io_rd, io_wr, mem_rd, mem_wr, io_sel_ff, mem_sel_ff, io_chrdy_ff, sram_sel_ff;
    logic ctrl_reg_sel_ff, irq_out_ff, irq_share_en_ff, board_reset_ff, local_loop_ff;
    logic remote_loop_ff, line_mode_ok_ff;
    logic [2:0] irq_code_ff;
    iahc_line_mode_t line_mode_ff;
    int mismatches = 0, n_compared = 0, cycles = 0, n;
    iahc_row_t rows [12] = '{'{1'b1, 3'h0, 8'hFF, 8'hCF}, '{1'b1, 3'h1, 8'hFF, 8'h1F},
        '{1'b0, 3'h4, 8'h00, 8'h40}, '{1'b1, 3'h1, 8'h1F, 8'h1F}, '{1'b0, 3'h4, 8'h00, 8'h00},
        '{1'b1, 3'h2, 8'hFF, 8'h60}, '{1'b1, 3'h4, 8'hFF, 8'h80}, '{1'b0, 3'h5, 8'h00, 8'h0D},
        '{1'b1, 3'h5, 8'hFE, 8'hDE}, '{1'b0, 3'h6, 8'h00, 8'hFF}, '{1'b0, 3'h7, 8'h00, 8'hFF},
        '{1'b0, 3'h3, 8'h00, 8'h38}};
    iahc_isa_host_model u_host (.*);
    iahc_isa_adapter_host_control u_dut (.*);
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input string what, input logic [17:0] e, input logic [17:0] g);
        n_compared++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", what, e, g);
            mismatches++;
        end
    endtask
    task automatic rw(input logic wr, input logic [2:0] ofs, input logic [7:0] d);
        u_host.io_cycle(wr, 10'h300 + {7'h00, ofs}, d, q, n);
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        chk("board_reset", 18'h1, board_reset_ff);
        repeat (12) @(negedge mclk);
        chk("board_reset", 18'h0, board_reset_ff);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                rw(1'b1, rows[i].ofs, rows[i].d);
            end
            rw(1'b0, rows[i].ofs, 8'h00);
            chk("register", rows[i].e, q);
        end
        chk("loop_share", 18'h7, {15'h0000, local_loop_ff, remote_loop_ff, irq_share_en_ff});
        $display("test register table done");
        for (int c = 0; c < 16; c++) begin
            rw(1'b1, 3'h5, {4'h1, c[3:0]});
            @(negedge mclk);
            chk("line_mode", SUP[c] ? c[3:0] : 4'h0, line_mode_ff);
            chk("mode_ok", SUP[c], line_mode_ok_ff);
        end
        rw(1'b1, 3'h5, 8'h0F);
        @(negedge mclk);
        chk("switch_mode", IAHC_LM_RS530, line_mode_ff);
        $display("test line modes done");
        rw(1'b1, 3'h3, 8'h7F);
        @(negedge mclk);
        chk("board_reset", 18'h0, board_reset_ff);
        rw(1'b1, 3'h3, 8'h80);
        rw(1'b0, 3'h3, 8'h00);
        chk("reset_status", 18'h28, q);
        repeat (12) @(negedge mclk);
        rw(1'b0, 3'h3, 8'h00);
        chk("reset_status", 18'h38, q);
        controller_irq = 1'b1;
        rw(1'b0, 3'h3, 8'h00);
        chk("pending", 18'h18, q);
        chk("irq_out", 18'h0, irq_out_ff);
        rw(1'b1, 3'h1, 8'h22);
        @(negedge mclk);
        chk("irq_out", 18'h1, irq_out_ff);
        chk("irq_code", 18'h1, {15'h0000, irq_code_ff});
        rw(1'b0, 3'h4, 8'h00);
        chk("irq_status", 18'hC0, q);
        controller_irq = 1'b0;
        $display("test reset and interrupt done");
        rw(1'b1, 3'h0, 8'hC3);
        u_host.mem_cycle(1'b0, 20'h88123);
        chk("window_sel", 18'h3, {16'h0000, mem_sel_ff, sram_sel_ff});
        chk("window_addr", 18'h0C123, sram_addr_ff);
        rw(1'b1, 3'h0, 8'h83);
        u_host.mem_cycle(1'b1, 20'h88010);
        chk("ctrl_sel", 18'h6, {15'h0000, mem_sel_ff, ctrl_reg_sel_ff, sram_sel_ff});
        u_host.mem_cycle(1'b0, 20'h88200);
        chk("ctrl_above", 18'h5, {15'h0000, mem_sel_ff, ctrl_reg_sel_ff, sram_sel_ff});
        u_host.mem_cycle(1'b0, 20'h8C000);
        chk("outside", 18'h0, {17'h00000, mem_sel_ff});
        u_host.mem_cycle(1'b0, 20'h08123);
        chk("below_window", 18'h0, {17'h00000, mem_sel_ff});
        rw(1'b1, 3'h0, 8'h03);
        u_host.mem_cycle(1'b0, 20'h88010);
        chk("disabled", 18'h0, {17'h00000, mem_sel_ff});
        ctrl_dma_addr = 18'h2ABCD;
        @(negedge mclk);
        chk("dma_addr", 18'h2ABCD, ctrl_sram_addr_ff);
        u_host.io_cycle(1'b0, 10'h2FB, 8'h00, q, n);
        chk("outside_io", 18'h0, {io_sel_ff, q});
        u_host.io_cycle(1'b0, 10'h100, 8'h00, q, n);
        chk("below_io", 18'h0, {9'h000, io_sel_ff, q});
        $display("test window done");
        rst = 1'b1;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        repeat (12) @(negedge mclk);
        rw(1'b0, 3'h2, 8'h00);
        chk("wait_reset", 18'h20, q);
        chk("wait_cycles", 18'h4, n[17:0]);
        rw(1'b0, 3'h4, 8'h00);
        chk("share_reset", 18'h0, q);
        rw(1'b0, 3'h5, 8'h00);
        chk("line_reset", 18'h0D, q);
        $display("test second reset done");
        summarize();
    end
endmodule
